// ### core/remote_arbiter_defines.vh
/*
  constants for the remote read arbiter: state codes, select codes,
  apb register offsets and field positions, reset values.
  assumes inclusion by bare name from core/ sources.
*/
`ifndef REMOTE_ARBITER_DEFINES_VH
`define REMOTE_ARBITER_DEFINES_VH

// ----------------------------------------------------------------------
// state codes
// ----------------------------------------------------------------------
`define ST_IDLE1      4'h0
`define ST_IDLE2      4'h1
`define ST_TAKE       4'h2
`define ST_ACCESS     4'h3
`define ST_RD_RIC     4'h4
`define ST_RD_PCL     4'h5
`define ST_RD_PCH     4'h6
`define ST_RD_DATA_MEMORY    4'h7
`define ST_RD_INSTRUCTION_MEMORY    4'h8
`define ST_TERM       4'h9
`define ST_REL        4'ha
`define ST_REL_DATA_MEMORY   4'hb
`define ST_IDLE3      4'hc

// ----------------------------------------------------------------------
// memory select codes
// ----------------------------------------------------------------------
`define MSEL_DATA_MEMORY     2'h0
`define MSEL_INSTRUCTION_MEMORY     2'h1
`define MSEL_PCL      2'h2
`define MSEL_PCH      2'h3

// ----------------------------------------------------------------------
// apb register map
// ----------------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_CONFIG    12'h004
`define OFS_PC        12'h008
`define OFS_STATUS    12'h00c

// ctrl fields
`define CTRL_MSEL_LO  0
`define CTRL_LOR_BIT  2
// config fields
`define CFG_DW_LO     0
`define CFG_IW_LO     4

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_MSEL      2'h0
`define RST_DW        3'h0
`define RST_IW        2'h0
`define RST_PC        16'h0000

`endif

// ### core/wait_counter.v
/*
  down counter for programmed wait states, with load and done flag.
  assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps

module wait_counter (
  // clock and reset
  input  wire       clk_sys,
  input  wire       reset_n,
  // control
  input  wire       load,
  input  wire [2:0] load_val,
  input  wire       step,
  // status
  output wire       done
);

  reg [2:0] count_r;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 3'h0;
    end else if (load) begin
      count_r <= load_val;
    end else if (step && count_r != 3'h0) begin
      count_r <= count_r - 3'h1;
    end
  end

  assign done = (count_r == 3'h0);

endmodule // wait_counter

// ### core/remote_read_arbiter.v
/*
  remote read arbiter, buffered-read mode: shares the local address and
  multiplexed address/data buses between the local timing unit and a
  remote processor. control, config and pc are reached over apb.
  assumes remote pins arrive asynchronously and are synchronised here;
  local timing-unit signals and memory data are on clk_sys.
*/
`timescale 1ns/1ps
`include "remote_arbiter_defines.vh"

module remote_read_arbiter (
  // clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // remote processor pins
  input  wire        remote_read_strobe_n,
  input  wire        remote_access_enable_n,
  input  wire        cmd_select,
  input  wire        wait_n,
  output wire        transfer_ack,
  output wire        bus_owner_local,
  // local timing unit
  input  wire        local_bus_request,
  input  wire        data_memory_hold,
  output wire        local_bus_grant,
  output wire        local_stall,
  // memory side
  input  wire [15:0] last_data_addr,
  input  wire [15:0] instr_word,
  output reg         mem_read_n,
  // address bus upper byte
  output reg  [7:0]  addr_out,
  output reg         addr_oe,
  // multiplexed address/data bus
  output reg  [7:0]  ad_out,
  output reg         ad_oe
);

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  reg [1:0] rd_s_r;
  reg [1:0] en_s_r;
  reg [1:0] cmd_s_r;
  reg [1:0] wait_s_r;

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_s_r   <= 2'h3;
      en_s_r   <= 2'h3;
      cmd_s_r  <= 2'h0;
      wait_s_r <= 2'h3;
    end else begin
      rd_s_r   <= {rd_s_r[0], remote_read_strobe_n};
      en_s_r   <= {en_s_r[0], remote_access_enable_n};
      cmd_s_r  <= {cmd_s_r[0], cmd_select};
      wait_s_r <= {wait_s_r[0], wait_n};
    end
  end

  wire rd_req   = ~rd_s_r[1] & ~en_s_r[1];
  wire cmd_hi   = cmd_s_r[1];
  wire wait_hi  = wait_s_r[1];
  // raw request for the immediate acknowledge and owner paths
  wire rd_req_a = ~remote_read_strobe_n & ~remote_access_enable_n;

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  reg  [1:0]  msel_r;
  reg         lockout_r;
  reg  [2:0]  dw_r;
  reg  [1:0]  iw_r;
  reg  [15:0] pc_r;
  reg         high_byte_flag_r;
  reg  [3:0]  state_r;
  reg  [3:0]  state_nxt;
  reg  [1:0]  tgt_r;
  reg         tgt_cmd_r;
  reg         grant_r;

  wire apb_wr = psel & penable & pwrite;
  wire apb_rd = psel & ~penable & ~pwrite;
  wire hit    = (paddr == `OFS_CTRL) | (paddr == `OFS_CONFIG) |
                (paddr == `OFS_PC)   | (paddr == `OFS_STATUS);

  // zero-wait slave: every access completes in its first access cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;

  wire dw_done;
  wire iw_done;
  wire load_waits = (state_r == `ST_TAKE);
  wire in_data_memory    = (state_r == `ST_RD_DATA_MEMORY);
  wire in_instruction_memory    = (state_r == `ST_RD_INSTRUCTION_MEMORY);

  // --------------------------------------------------------------------
  // programmed wait counters
  // --------------------------------------------------------------------
  wait_counter u_dw (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .load     (load_waits),
    .load_val (dw_r),
    .step     (in_data_memory),
    .done     (dw_done)
  );

  wait_counter u_iw (
    .clk_sys  (clk_sys),
    .reset_n  (reset_n),
    .load     (load_waits),
    .load_val ({1'b0, iw_r}),
    .step     (in_instruction_memory),
    .done     (iw_done)
  );

  wire is_idle = (state_r == `ST_IDLE1) | (state_r == `ST_IDLE2) |
                 (state_r == `ST_IDLE3);

  // --------------------------------------------------------------------
  // state machine
  // --------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE1, `ST_IDLE3: begin
        if (rd_req) begin
          if (lockout_r || grant_r)
            state_nxt = `ST_IDLE2;
          else if (local_bus_request)
            state_nxt = `ST_IDLE1;
          else
            state_nxt = `ST_TAKE;
        end else begin
          state_nxt = `ST_IDLE1;
        end
      end
      `ST_IDLE2: begin
        if (!rd_req)
          state_nxt = `ST_IDLE1;
        else if (!lockout_r && !grant_r && !local_bus_request)
          state_nxt = `ST_TAKE;
      end
      `ST_TAKE:   state_nxt = `ST_ACCESS;
      `ST_ACCESS: begin
        if (cmd_hi)
          state_nxt = `ST_RD_RIC;
        else case (msel_r)
          `MSEL_PCL:  state_nxt = `ST_RD_PCL;
          `MSEL_PCH:  state_nxt = `ST_RD_PCH;
          `MSEL_DATA_MEMORY: state_nxt = `ST_RD_DATA_MEMORY;
          default:    state_nxt = `ST_RD_INSTRUCTION_MEMORY;
        endcase
      end
      `ST_RD_RIC, `ST_RD_PCL, `ST_RD_PCH: begin
        if (wait_hi)
          state_nxt = `ST_TERM;
      end
      `ST_RD_DATA_MEMORY: begin
        if (dw_done && wait_hi)
          state_nxt = `ST_TERM;
      end
      `ST_RD_INSTRUCTION_MEMORY: begin
        if (iw_done && wait_hi)
          state_nxt = `ST_TERM;
      end
      `ST_TERM: begin
        if (!rd_req)
          state_nxt = (tgt_r == `MSEL_DATA_MEMORY && !tgt_cmd_r) ?
                      `ST_REL_DATA_MEMORY : `ST_REL;
      end
      `ST_REL:      state_nxt = `ST_IDLE1;
      `ST_REL_DATA_MEMORY: state_nxt = `ST_IDLE3;
      default:      state_nxt = `ST_IDLE1;
    endcase
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_r   <= `ST_IDLE1;
      tgt_r     <= `MSEL_DATA_MEMORY;
      tgt_cmd_r <= 1'b0;
      grant_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == `ST_ACCESS) begin
        tgt_r     <= msel_r;
        tgt_cmd_r <= cmd_hi;
      end
      // grant only while idle, buses unused, hold input high
      if (is_idle && data_memory_hold && local_bus_request && state_nxt != `ST_TAKE)
        grant_r <= 1'b1;
      else if (!local_bus_request || !is_idle)
        grant_r <= 1'b0;
    end
  end

  // clock level is high in the first half of each cycle
  wire first_half = clk_sys;

  // --------------------------------------------------------------------
  // local grant and stall
  // --------------------------------------------------------------------
  assign local_bus_grant = grant_r & is_idle;
  assign local_stall     = local_bus_request & ~is_idle;

  // --------------------------------------------------------------------
  // acknowledge and bus owner
  // --------------------------------------------------------------------
  wire in_access = (state_r == `ST_ACCESS) | (state_r == `ST_RD_RIC) |
                   (state_r == `ST_RD_PCL) | (state_r == `ST_RD_PCH) |
                   in_data_memory | in_instruction_memory;
  wire data_memory_tgt  = (tgt_r == `MSEL_DATA_MEMORY) & ~tgt_cmd_r;

  // a new request pulls ack low in every state with no transfer open
  wire rd_new = rd_req_a & (is_idle | (state_r == `ST_REL) |
                            (state_r == `ST_REL_DATA_MEMORY));

  // low while request pending and not yet in termination
  assign transfer_ack = ~(rd_new | (state_r == `ST_TAKE) |
                          in_access);

  assign bus_owner_local = in_access | (state_r == `ST_REL_DATA_MEMORY) |
                           ((state_r == `ST_TERM) &
                            (data_memory_tgt | rd_req_a));

  // --------------------------------------------------------------------
  // bus drive
  // --------------------------------------------------------------------
  wire float_now = (state_r == `ST_TAKE & ~first_half) | in_access |
                   (state_r == `ST_TERM) | (state_r == `ST_REL_DATA_MEMORY) |
                   ((state_r == `ST_REL | state_r == `ST_IDLE3) & first_half);
  wire data_memory_any  = (state_r == `ST_TAKE & msel_r == `MSEL_DATA_MEMORY & ~cmd_hi) |
                   (state_r == `ST_ACCESS & msel_r == `MSEL_DATA_MEMORY & ~cmd_hi) |
                   in_data_memory | ((state_r == `ST_TERM | state_r == `ST_REL_DATA_MEMORY) &
                   data_memory_tgt) | (state_r == `ST_IDLE3 & first_half);

  always @* begin
    addr_out   = last_data_addr[15:8];
    addr_oe    = ~float_now;
    ad_out     = {5'h0, lockout_r, msel_r};
    ad_oe      = ~(float_now & data_memory_any &
                   state_r != `ST_REL);
    mem_read_n = ~(in_data_memory |
                   (state_r == `ST_TERM & data_memory_tgt & first_half));
    if (state_r == `ST_RD_PCL || (state_r == `ST_TERM && !tgt_cmd_r &&
        tgt_r == `MSEL_PCL))
      ad_out = pc_r[7:0];
    else if (state_r == `ST_RD_PCH || (state_r == `ST_TERM && !tgt_cmd_r &&
             tgt_r == `MSEL_PCH))
      ad_out = pc_r[15:8];
    else if (in_instruction_memory || (state_r == `ST_TERM && !tgt_cmd_r &&
             tgt_r == `MSEL_INSTRUCTION_MEMORY))
      ad_out = high_byte_flag_r ? instr_word[15:8] : instr_word[7:0];
  end

  // --------------------------------------------------------------------
  // apb registers, pc and high-byte flag
  // --------------------------------------------------------------------
  // flag toggles once per finished instruction byte; pc steps once per finished high byte
  wire instruction_memory_done = (state_r == `ST_REL) & ~tgt_cmd_r & (tgt_r == `MSEL_INSTRUCTION_MEMORY);

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      msel_r           <= `RST_MSEL;
      lockout_r        <= 1'b0;
      dw_r             <= `RST_DW;
      iw_r             <= `RST_IW;
      pc_r             <= `RST_PC;
      high_byte_flag_r <= 1'b0;
    end else begin
      if (instruction_memory_done) begin
        high_byte_flag_r <= ~high_byte_flag_r;
        if (high_byte_flag_r)
          pc_r <= pc_r + 16'h0001;
      end
      if (apb_wr && paddr == `OFS_CTRL) begin
        msel_r    <= pwdata[`CTRL_MSEL_LO+1:`CTRL_MSEL_LO];
        lockout_r <= pwdata[`CTRL_LOR_BIT];
        if (pwdata[`CTRL_MSEL_LO+1:`CTRL_MSEL_LO] == `MSEL_INSTRUCTION_MEMORY)
          high_byte_flag_r <= 1'b0;
      end
      if (apb_wr && paddr == `OFS_CONFIG) begin
        dw_r <= pwdata[`CFG_DW_LO+2:`CFG_DW_LO];
        iw_r <= pwdata[`CFG_IW_LO+1:`CFG_IW_LO];
      end
      if (apb_wr && paddr == `OFS_PC && !instruction_memory_done)
        pc_r <= pwdata[15:0];
    end
  end

  // read data snapshot taken in the setup cycle, held through access
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd) begin
      case (paddr)
        `OFS_CTRL:   prdata <= {29'h0, lockout_r, msel_r};
        `OFS_CONFIG: prdata <= {26'h0, iw_r, 1'b0, dw_r};
        `OFS_PC:     prdata <= {16'h0, pc_r};
        `OFS_STATUS: prdata <= {26'h0, high_byte_flag_r, grant_r, state_r};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // remote_read_arbiter

// ### verif/arb_checker_asserts.sv
/*
  concurrent checks on the remote read port and the local grant.
  assumes a bind to remote_read_arbiter and one clock domain.
*/
`timescale 1ns/1ps
module arb_checker (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // remote and local inputs
  input wire remote_read_strobe_n,
  input wire remote_access_enable_n,
  input wire wait_n,
  input wire local_bus_request,
  input wire data_memory_hold,
  // arbiter outputs
  input wire transfer_ack,
  input wire bus_owner_local,
  input wire local_bus_grant,
  input wire local_stall,
  input wire mem_read_n,
  input wire addr_oe,
  input wire ad_oe
);
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  wire req = !remote_read_strobe_n && !remote_access_enable_n;

  // ------
  // checks
  // ------
  a_ack_waits: assert property (
    req && !bus_owner_local |-> !transfer_ack) else $error("ack high while waiting");
  a_owner_ack: assert property (
    $rose(bus_owner_local) |-> !transfer_ack && !local_bus_grant) else $error("owner rose badly");
  a_take_delay: assert property (
    $rose(bus_owner_local) |-> !$past(transfer_ack, 2)) else $error("takeover too early");
  a_local_refused: assert property (
    bus_owner_local |-> !local_bus_grant) else $error("grant during remote access");
  a_stall_local: assert property (
    (bus_owner_local && local_bus_request) [*2] |-> local_stall) else $error("no stall");
  a_grant_cause: assert property (
    $rose(local_bus_grant) |-> data_memory_hold && local_bus_request) else $error("stray grant");
  a_read_float: assert property (
    !mem_read_n |-> bus_owner_local && !addr_oe && !ad_oe) else $error("strobe with bus driven");
  a_wait_extend: assert property (
    (!transfer_ack && bus_owner_local && !wait_n) [*4] |=> !transfer_ack) else $error("wait lost");
  a_term_hold: assert property (
    transfer_ack && bus_owner_local && req ##1 req |-> bus_owner_local) else $error("term left");
  a_data_memory_owner: assert property (
    transfer_ack && bus_owner_local && !ad_oe && req ##1 !req |-> bus_owner_local)
    else $error("owner fell early");
endmodule // arb_checker

bind remote_read_arbiter arb_checker chk_u (.clk_sys, .reset_n, .remote_read_strobe_n,
  .remote_access_enable_n, .wait_n, .local_bus_request, .data_memory_hold, .transfer_ack,
  .bus_owner_local, .local_bus_grant, .local_stall, .mem_read_n, .addr_oe, .ad_oe);

// ### verif/remote_host.sv
/*
  remote processor model: buffered reads with wait and hold control.
  assumes design outputs settle before each rising edge.
*/
`timescale 1ns/1ps
module remote_host (
  // clock
  input wire clk_sys,
  // arbiter outputs
  input wire       transfer_ack,
  input wire       bus_owner_local,
  input wire       mem_read_n,
  input wire [7:0] ad_out,
  input wire       ad_oe,
  // remote pins
  output logic remote_read_strobe_n = 1'h1,
  output logic remote_access_enable_n = 1'h1,
  output wire  cmd_select,
  output logic wait_n = 1'h1
);
  logic cmd_r = 1'h0;
  logic busy = 1'h0;
  logic pat = 1'h0;
  // select line toggles outside frames
  always @(posedge clk_sys) pat <= ~pat;
  assign cmd_select = busy ? cmd_r : pat;

  task automatic rd(input logic cmd, input int wlow, input int hold, input int lim,
                    output logic [7:0] d, output logic oe, output logic ok,
                    output int acc, output int rds, output int tail);
    int n;
    begin
      n = 0;
      acc = 0;
      rds = 0;
      tail = 0;
      busy <= 1'h1;
      cmd_r <= cmd;
      remote_access_enable_n <= 1'h0;
      remote_read_strobe_n <= 1'h0;
      wait_n <= (wlow == 0);
      // stay in the cycle while ack is low
      do begin
        @(posedge clk_sys);
        n++;
        if (bus_owner_local && !transfer_ack) acc++;
        if (!mem_read_n) rds++;
        if (acc >= wlow) wait_n <= 1'h1;
      end while (transfer_ack !== 1'h1 && n < lim);
      d = ad_out;
      oe = ad_oe;
      ok = transfer_ack;
      repeat (hold) @(posedge clk_sys);
      remote_read_strobe_n <= 1'h1;
      remote_access_enable_n <= 1'h1;
      repeat (6) begin
        @(posedge clk_sys);
        if (bus_owner_local) tail++;
      end
      busy <= 1'h0;
    end
  endtask
endmodule // remote_host

// ### verif/testbench.sv
/*
  bench for remote_read_arbiter: apb master, local unit, scenarios.
  assumes remote_host beside the design and the bound checker.
*/
`timescale 1ns/1ps
`include "remote_arbiter_defines.vh"
module testbench;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, local_bus_request = 1'h0;
  logic data_memory_hold = 1'h1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [15:0] last_data_addr = 16'ha5c3, instr_word = 16'hb7c4;
  logic [7:0] addr_out, ad_out, d;
  logic pready, pslverr, er, transfer_ack, bus_owner_local, local_bus_grant, local_stall;
  logic remote_read_strobe_n, remote_access_enable_n, cmd_select, wait_n, mem_read_n;
  logic addr_oe, ad_oe, oe, ok;
  int failures = 0, n_tests = 0, acc, rds, tail;

  always #12.5 clk_sys = ~clk_sys;
  remote_read_arbiter dut_u (.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .remote_read_strobe_n, .remote_access_enable_n,
    .cmd_select, .wait_n, .transfer_ack, .bus_owner_local, .local_bus_request, .data_memory_hold,
    .local_bus_grant, .local_stall, .last_data_addr, .instr_word, .mem_read_n, .addr_out,
    .addr_oe, .ad_out, .ad_oe);
  remote_host host_u (.clk_sys, .transfer_ack, .bus_owner_local, .mem_read_n, .ad_out,
    .ad_oe, .remote_read_strobe_n, .remote_access_enable_n, .cmd_select, .wait_n);

  // -------
  // helpers
  // -------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_tests++;
      if (got !== exp) begin
        failures++;
        $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask

  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'h1;
      do @(posedge clk_sys); while (pready !== 1'h1);
      rv = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
    end
  endtask

  task rdr(input logic cmd, input int wlow, input int hold, input int lim);
    host_u.rd(cmd, wlow, hold, lim, d, oe, ok, acc, rds, tail);
  endtask

  // ---------
  // scenarios
  // ---------
  task t_reset;
    begin
      chk("rst_ack", 1'h1, transfer_ack);
      chk("rst_owner", 1'h0, bus_owner_local);
      chk("rst_grant", 1'h0, local_bus_grant);
      chk("rst_read", 1'h1, mem_read_n);
      chk("rst_oe", 2'h3, {addr_oe, ad_oe});
      chk("rst_ad", 8'h00, ad_out);
    end
  endtask

  task t_regs;
    begin
      apb(1'h1, `OFS_CONFIG, 32'h12);
      apb(1'h1, `OFS_PC, 32'h12fe);
      apb(1'h0, `OFS_CONFIG, 32'h0);
      chk("config", 32'h12, rv);
      apb(1'h0, 12'h010, 32'h0);
      chk("unmapped_err", 1'h1, er);
    end
  endtask

  task t_sel;
    logic [7:0] exp [0:2];
    begin
      exp = '{8'h02, 8'hfe, 8'h12};
      for (int i = 0; i < 3; i++) begin
        apb(1'h1, `OFS_CTRL, (i == 2) ? 32'h3 : 32'h2);
        rdr(i == 0, 0, i, 100);
        chk("sel_data", exp[i], d);
        chk("sel_oe", 1'h1, oe);
        chk("sel_ack", 1'h1, ok);
        chk("sel_tail", 0, tail);
        apb(1'h0, `OFS_STATUS, 32'h0);
        chk("sel_idle", `ST_IDLE1, rv[3:0]);
      end
    end
  endtask

  task t_data_memory;
    begin
      apb(1'h1, `OFS_CTRL, 32'h0);
      rdr(1'h0, 0, 0, 100);
      chk("dm_oe", 1'h0, oe);
      chk("dm_ack", 1'h1, ok);
      chk("dm_acc", 4, acc);
      chk("dm_strobe", 1'h1, rds >= 3);
      chk("dm_tail", 1'h1, tail != 0);
      rdr(1'h0, 7, 2, 100);
      chk("dm_wait", 1'h1, acc > 6);
    end
  endtask

  task t_instruction_memory;
    begin
      apb(1'h1, `OFS_CTRL, 32'h1);
      rdr(1'h0, 0, 0, 100);
      chk("im_lo", 8'hc4, d);
      chk("im_acc", 3, acc);
      apb(1'h0, `OFS_STATUS, 32'h0);
      chk("im_flag", 1'h1, rv[5]);
      rdr(1'h0, 0, 1, 100);
      chk("im_hi", 8'hb7, d);
      apb(1'h0, `OFS_PC, 32'h0);
      chk("im_pc", 32'h12ff, rv);
      rdr(1'h0, 0, 0, 100);
      apb(1'h1, `OFS_CTRL, 32'h1);
      apb(1'h0, `OFS_STATUS, 32'h0);
      chk("im_flag_clr", 1'h0, rv[5]);
    end
  endtask

  task t_lock;
    begin
      apb(1'h1, `OFS_CTRL, 32'h4);
      fork
        rdr(1'h1, 0, 0, 20);
        begin
          repeat (8) @(posedge clk_sys);
          apb(1'h0, `OFS_STATUS, 32'h0);
          chk("lock_state", `ST_IDLE2, rv[3:0]);
        end
      join
      chk("lock_ack", 1'h0, ok);
      chk("lock_owner", 0, acc);
      apb(1'h1, `OFS_CTRL, 32'h0);
    end
  endtask

  task t_local;
    begin
      data_memory_hold <= 1'h0;
      local_bus_request <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk("no_grant", 1'h0, local_bus_grant);
      data_memory_hold <= 1'h1;
      repeat (4) @(posedge clk_sys);
      chk("grant", 1'h1, local_bus_grant);
      fork
        rdr(1'h1, 0, 3, 200);
        begin
          repeat (10) @(posedge clk_sys);
          chk("l_ack", 1'h0, transfer_ack);
          chk("l_owner", 1'h0, bus_owner_local);
          local_bus_request <= 1'h0;
          for (int i = 0; i < 20 && bus_owner_local !== 1'h1; i++) @(posedge clk_sys);
          local_bus_request <= 1'h1;
          repeat (2) @(posedge clk_sys);
          chk("l_refuse", 1'h0, local_bus_grant);
          chk("l_stall", 1'h1, local_stall);
          local_bus_request <= 1'h0;
        end
      join
      chk("l_done", 1'h1, ok);
    end
  endtask

  initial begin
    repeat (3) @(posedge clk_sys);
    t_reset;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk("idle_addr", 8'ha5, addr_out);
    t_regs;
    t_sel;
    t_data_memory;
    t_instruction_memory;
    t_lock;
    t_local;
    conclude;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    conclude;
  end
endmodule // testbench
